/* File: hw/touch_option_pkg.sv */
// package for touch key option, idle wake and debounce control
// assumes a byte-wide register port and a 100 MHz ref_clk
package touch_option_pkg;

  // register offsets
  localparam logic [7:0] function_option_select_addr = 8'h1f;
  localparam logic [7:0] sense_accumulate_count_addr = 8'h20;
  localparam logic [7:0] idle_entry_delay_addr       = 8'h23;
  localparam logic [7:0] idle_wake_level_addr        = 8'h24;
  localparam logic [7:0] idle_wake_check_level_addr  = 8'h25;
  localparam logic [7:0] debounce_count_addr         = 8'h26;

  // reset values
  localparam logic [4:0] function_option_select_rst = 5'h09;
  localparam logic [7:0] sense_accumulate_count_rst = 8'h02;
  localparam logic [7:0] idle_entry_delay_rst       = 8'h03;
  localparam logic [7:0] idle_wake_level_rst        = 8'h0a;
  localparam logic [7:0] idle_wake_check_level_rst  = 8'h05;
  localparam logic [7:0] debounce_count_rst         = 8'h02;

  // function option field positions
  localparam int touched_hold_enable_bit         = 0;
  localparam int reverse_touched_hold_enable_bit = 1;
  localparam int multi_key_select_bit            = 2;
  localparam int fast_baseline_tracking_bit      = 3;
  localparam int multi_touch_noise_select_bit    = 4;

  // clock period, timing in milliseconds, level scale and wake check count
  localparam int clk_period_ns       = 10;
  localparam int ns_per_ms           = 1000000;
  localparam int ms_cycles           = ns_per_ms / clk_period_ns;
  localparam int reverse_hold_ms     = 200;
  localparam int track_slow_ms       = 1000;
  localparam int track_fast_ms       = 200;
  localparam int idle_delay_step_ms  = 500;
  localparam int idle_duty_step_ms   = 100;
  localparam int hold_step_ms        = 1000;
  localparam int level_step_tenths   = 10;
  localparam int wake_check_hits     = 2;

  typedef struct packed {
    logic touched;
    logic reverse;
  } key_sample_t;

  typedef struct packed {
    logic       hold_enable;
    logic       reverse_enable;
    logic [7:0] hold_time;
    logic [7:0] debounce;
  } key_cfg_t;

  typedef enum logic [1:0] {
    st_active   = 2'b00,
    st_entering = 2'b01,
    st_idle     = 2'b10
  } idle_state_t;

endpackage : touch_option_pkg

/* File: hw/key_qualifier.sv */
// one key: debounce, touched hold release, reverse hold release
// assumes ms_tick is a one-cycle pulse every millisecond
`timescale 1ns/1ps
module key_qualifier (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire logic                         ms_tick,
  input  wire logic                         sample_valid,
  input  wire touch_option_pkg::key_sample_t sample,
  input  wire touch_option_pkg::key_cfg_t    cfg,
  output logic                              touched,
  output logic                              reinit
);

  logic [7:0]  streak;
  logic [17:0] hold_ms;
  logic [17:0] rev_ms;
  logic [17:0] hold_limit;
  logic        hold_expired;
  logic        rev_expired;

  assign hold_limit   = 18'(cfg.hold_time * touch_option_pkg::hold_step_ms);
  assign hold_expired = cfg.hold_enable && touched && (hold_ms > hold_limit);
  assign rev_expired  = cfg.reverse_enable &&
                        (rev_ms > 18'(touch_option_pkg::reverse_hold_ms));

  // debounce and release
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      touched <= 1'b0;
      streak  <= 8'h00;
      reinit  <= 1'b0;
    end
    else
    begin
      reinit <= hold_expired || rev_expired;
      if (hold_expired || rev_expired)
      begin
        touched <= 1'b0;
        streak  <= 8'h00;
      end
      else if (sample_valid)
      begin
        if (sample.touched == touched)
          streak <= 8'h00;
        else if (streak >= cfg.debounce)
        begin
          touched <= sample.touched;
          streak  <= 8'h00;
        end
        else
          streak <= streak + 8'h01;
      end
    end
  end

  // touched time in ms
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !touched || hold_expired)
      hold_ms <= 18'h00000;
    else if (ms_tick && hold_ms != 18'h3ffff)
      hold_ms <= hold_ms + 18'h00001;
  end

  // reverse touched time in ms
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !sample.reverse || rev_expired)
      rev_ms <= 18'h00000;
    else if (ms_tick && rev_ms != 18'h3ffff)
      rev_ms <= rev_ms + 18'h00001;
  end

endmodule : key_qualifier

/* File: hw/touch_key_option_idle_wake_control.sv */
// option, idle entry, idle wake and key result control of a touch sensor
// assumes all inputs are synchronous to ref_clk; registers reached by byte port
`timescale 1ns/1ps
module touch_key_option_idle_wake_control #(
  parameter int key_count     = 12,
  parameter int cycles_per_ms = touch_option_pkg::ms_cycles
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [7:0]           reg_rdata,
  input  wire logic [7:0]           key_hold_time,
  input  wire logic [2:0]           idle_duty_period,
  input  wire logic                 sample_valid,
  input  wire logic [key_count-1:0] raw_touched,
  input  wire logic [key_count-1:0] raw_reverse,
  input  wire logic [15:0]          touch_difference_value,
  input  wire logic [15:0]          touch_threshold,
  input  wire logic                 idle_request,
  output logic      [key_count-1:0] key_result,
  output logic      [key_count-1:0] key_reinit,
  output logic      [7:0]           accumulate_count,
  output logic                      baseline_track_tick,
  output logic                      idle_active,
  output logic                      wake_event
);

  logic [4:0]  function_option_select;
  logic [7:0]  sense_accumulate_count;
  logic [7:0]  idle_entry_delay;
  logic [7:0]  idle_wake_level;
  logic [7:0]  idle_wake_check_level;
  logic [7:0]  debounce_count;

  logic [$clog2(cycles_per_ms)-1:0] ms_div;
  logic                             ms_tick;
  logic [9:0]                       track_ms;
  logic [17:0]                      idle_ms;
  logic [1:0]                       check_hits;
  touch_option_pkg::idle_state_t    state;

  logic [key_count-1:0] accepted;
  logic [key_count-1:0] reinit_w;
  logic [key_count-1:0] lowest_key;
  logic                 several;
  logic [9:0]           track_limit;
  logic [17:0]          entry_limit;
  logic [17:0]          duty_limit;
  logic [23:0]          touch_difference_value_scaled;
  logic [23:0]          wake_lvl;
  logic [23:0]          check_lvl;
  logic                 over_check;
  logic                 over_wake;
  logic [1:0]           next_hits;
  touch_option_pkg::key_cfg_t cfg;

  // register writes
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      function_option_select <= touch_option_pkg::function_option_select_rst;
      sense_accumulate_count <= touch_option_pkg::sense_accumulate_count_rst;
      idle_entry_delay       <= touch_option_pkg::idle_entry_delay_rst;
      idle_wake_level        <= touch_option_pkg::idle_wake_level_rst;
      idle_wake_check_level  <= touch_option_pkg::idle_wake_check_level_rst;
      debounce_count         <= touch_option_pkg::debounce_count_rst;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        touch_option_pkg::function_option_select_addr: function_option_select <= reg_wdata[4:0];
        touch_option_pkg::sense_accumulate_count_addr: sense_accumulate_count <= reg_wdata;
        touch_option_pkg::idle_entry_delay_addr:       idle_entry_delay       <= reg_wdata;
        touch_option_pkg::idle_wake_level_addr:        idle_wake_level        <= reg_wdata;
        touch_option_pkg::idle_wake_check_level_addr:  idle_wake_check_level  <= reg_wdata;
        touch_option_pkg::debounce_count_addr:         debounce_count         <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        touch_option_pkg::function_option_select_addr: reg_rdata <= {3'h0, function_option_select};
        touch_option_pkg::sense_accumulate_count_addr: reg_rdata <= sense_accumulate_count;
        touch_option_pkg::idle_entry_delay_addr:       reg_rdata <= idle_entry_delay;
        touch_option_pkg::idle_wake_level_addr:        reg_rdata <= idle_wake_level;
        touch_option_pkg::idle_wake_check_level_addr:  reg_rdata <= idle_wake_check_level;
        touch_option_pkg::debounce_count_addr:         reg_rdata <= debounce_count;
        default:                                       reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      accumulate_count <= touch_option_pkg::sense_accumulate_count_rst;
    else
      accumulate_count <= sense_accumulate_count;
  end

  // millisecond tick
  assign ms_tick = (ms_div == ($clog2(cycles_per_ms))'(cycles_per_ms - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || ms_tick)
      ms_div <= '0;
    else
      ms_div <= ms_div + 1'b1;
  end

  // per key qualification
  assign cfg.hold_enable    = function_option_select[touch_option_pkg::touched_hold_enable_bit];
  assign cfg.reverse_enable =
    function_option_select[touch_option_pkg::reverse_touched_hold_enable_bit];
  assign cfg.hold_time      = key_hold_time;
  assign cfg.debounce       = debounce_count;

  genvar k;
  generate
    for (k = 0; k < key_count; k++)
    begin : g_key
      key_qualifier u_key (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .ms_tick      (ms_tick),
        .sample_valid (sample_valid),
        .sample       ({raw_touched[k], raw_reverse[k]}),
        .cfg          (cfg),
        .touched      (accepted[k]),
        .reinit       (reinit_w[k])
      );
    end
  endgenerate

  // key result selection
  assign lowest_key = accepted & (~accepted + 1'b1);
  assign several    = |(accepted & (accepted - 1'b1));

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      key_result <= '0;
      key_reinit <= '0;
    end
    else
    begin
      key_reinit <= reinit_w;
      if (function_option_select[touch_option_pkg::multi_key_select_bit])
        key_result <= accepted;
      else if (several &&
               function_option_select[touch_option_pkg::multi_touch_noise_select_bit])
        key_result <= '0;
      else
        key_result <= lowest_key;
    end
  end

  // baseline tracking interval
  assign track_limit = function_option_select[touch_option_pkg::fast_baseline_tracking_bit] ?
                       10'(touch_option_pkg::track_fast_ms - 1) :
                       10'(touch_option_pkg::track_slow_ms - 1);

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      track_ms            <= 10'h000;
      baseline_track_tick <= 1'b0;
    end
    else
    begin
      baseline_track_tick <= ms_tick && (track_ms >= track_limit);
      if (ms_tick)
        track_ms <= (track_ms >= track_limit) ? 10'h000 : track_ms + 10'h001;
    end
  end

  // idle levels, compared as difference times ten
  assign touch_difference_value_scaled = 24'(touch_difference_value * touch_option_pkg::level_step_tenths);
  assign wake_lvl    = 24'(touch_threshold) * 24'(idle_wake_level);
  assign check_lvl   = 24'(touch_threshold) * 24'(idle_wake_check_level);
  assign over_check  = touch_difference_value_scaled > check_lvl;
  assign over_wake   = touch_difference_value_scaled > wake_lvl;
  assign next_hits   = !over_check ? 2'h0 :
                       (check_hits == 2'(touch_option_pkg::wake_check_hits)) ?
                       check_hits : check_hits + 2'h1;
  assign entry_limit = 18'((idle_entry_delay + 1) * touch_option_pkg::idle_delay_step_ms);
  assign duty_limit  = 18'((idle_duty_period + 1) * touch_option_pkg::idle_duty_step_ms);

  // idle entry and wake sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state       <= touch_option_pkg::st_active;
      idle_ms     <= 18'h00000;
      check_hits  <= 2'h0;
      idle_active <= 1'b0;
      wake_event  <= 1'b0;
    end
    else
    begin
      wake_event <= 1'b0;
      case (state)
        touch_option_pkg::st_active:
        begin
          idle_ms    <= 18'h00000;
          check_hits <= 2'h0;
          if (idle_request)
            state <= touch_option_pkg::st_entering;
        end
        touch_option_pkg::st_entering:
        begin
          if (|accepted)
            state <= touch_option_pkg::st_active;
          else if (ms_tick)
          begin
            if (idle_ms + 18'h00001 >= entry_limit)
            begin
              state       <= touch_option_pkg::st_idle;
              idle_active <= 1'b1;
              idle_ms     <= 18'h00000;
            end
            else
              idle_ms <= idle_ms + 18'h00001;
          end
        end
        touch_option_pkg::st_idle:
        begin
          if (ms_tick)
          begin
            if (idle_ms + 18'h00001 >= duty_limit)
            begin
              idle_ms    <= 18'h00000;
              check_hits <= next_hits;
              if (next_hits == 2'(touch_option_pkg::wake_check_hits) && over_wake)
              begin
                state       <= touch_option_pkg::st_active;
                idle_active <= 1'b0;
                wake_event  <= 1'b1;
              end
            end
            else
              idle_ms <= idle_ms + 18'h00001;
          end
        end
        default:
        begin
          state       <= touch_option_pkg::st_active;
          idle_active <= 1'b0;
        end
      endcase
    end
  end

endmodule : touch_key_option_idle_wake_control

/* File: verif/touch_key_option_idle_wake_control_properties.sv */
// checker for the option, idle wake and key result block
// assumes binding to the block's top module, one clock domain
`timescale 1ns/1ps
module touch_ctrl_checker #(
  parameter int key_count = 12
) (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [7:0]           reg_rdata,
  input wire logic [key_count-1:0] key_result,
  input wire logic [key_count-1:0] key_reinit,
  input wire logic [7:0]           accumulate_count,
  input wire logic                 baseline_track_tick,
  input wire logic                 idle_active,
  input wire logic                 wake_event
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  chk_reinit_clears_key: assert property
    (|key_reinit |-> (key_result & key_reinit) == '0)
    else $error("released key still reported");
  chk_reinit_one_cycle: assert property
    (|key_reinit |=> (key_reinit & $past(key_reinit)) == '0)
    else $error("release pulse too long");
  chk_wake_ends_idle: assert property
    (wake_event |-> !idle_active && $past(idle_active))
    else $error("wake without leaving idle");
  chk_wake_one_cycle: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  chk_idle_exit_wake: assert property ($fell(idle_active) |-> wake_event)
    else $error("idle left without wake");
  chk_acc_copy_out: assert property
    (reg_write && reg_addr == 8'h20 |=> ##1 accumulate_count == $past(reg_wdata, 2))
    else $error("accumulate count not copied");
  chk_option_top_zero: assert property
    (reg_read && reg_addr == 8'h1f |=> reg_rdata[7:5] == 3'h0)
    else $error("option reserved bits set");
  chk_unmapped_reads: assert property
    (reg_read && !(reg_addr inside {8'h1f, 8'h20, [8'h23:8'h26]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_track_gap_min: assert property
    (baseline_track_tick |=> !baseline_track_tick [*8])
    else $error("tracking ticks too close");

  cover property (wake_event);
  cover property (|key_reinit);
  cover property ($rose(idle_active));
endmodule : touch_ctrl_checker

bind touch_key_option_idle_wake_control touch_ctrl_checker #(.key_count(key_count)) chk_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .key_result(key_result),
  .key_reinit(key_reinit), .accumulate_count(accumulate_count),
  .baseline_track_tick(baseline_track_tick), .idle_active(idle_active), .wake_event(wake_event)
);

/* File: verif/touch_host_model.sv */
// host side of the byte register port
// assumes the block samples strobes on the rising edge of ref_clk
`timescale 1ns/1ps
module touch_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // idle bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : touch_host_model

/* File: verif/touch_key_option_idle_wake_control_tb.sv */
// testbench for the option, idle wake and key result block
// assumes a shortened millisecond of ten ref_clk cycles
`timescale 1ns/1ps
module touch_key_option_idle_wake_control_tb;
  localparam int         cyc_ms = 10;
  localparam logic [7:0] adr [7] = '{8'h1f, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26, 8'h21};
  localparam logic [7:0] rst [7] = '{8'h09, 8'h02, 8'h03, 8'h0a, 8'h05, 8'h02, 8'h00};
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, accumulate_count;
  logic        reg_write, reg_read, baseline_track_tick, idle_active, wake_event;
  logic [7:0]  key_hold_time = 8'h01;
  logic [2:0]  idle_duty_period = 3'h0;
  logic        sample_valid = 1'b0;
  logic        idle_request = 1'b0;
  logic [11:0] raw_touched = 12'h000;
  logic [11:0] raw_reverse = 12'h000;
  logic [11:0] key_result, key_reinit;
  logic [15:0] touch_difference_value = 16'h0050;
  logic [15:0] touch_threshold = 16'h0064;
  int          fail_count = 0;
  int          checks = 0;

  touch_key_option_idle_wake_control #(.key_count(12), .cycles_per_ms(cyc_ms))
    touch_key_option_idle_wake_control_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .key_hold_time(key_hold_time), .idle_duty_period(idle_duty_period),
    .sample_valid(sample_valid), .raw_touched(raw_touched), .raw_reverse(raw_reverse),
    .touch_difference_value(touch_difference_value), .touch_threshold(touch_threshold),
    .idle_request(idle_request), .key_result(key_result), .key_reinit(key_reinit),
    .accumulate_count(accumulate_count), .baseline_track_tick(baseline_track_tick),
    .idle_active(idle_active), .wake_event(wake_event));

  touch_host_model host_inst (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read));

  always #5 ref_clk = ~ref_clk;

  task automatic close_out();
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic pick(input int w);
    case (w)
      0: return baseline_track_tick;
      1: return idle_active;
      2: return wake_event;
      default: return key_reinit[w - 3];
    endcase
  endfunction : pick

  task automatic wait_for(input int w, input int lim, output int n);
    n = 0;
    while (pick(w) !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_for

  task automatic samp(input logic [11:0] t, input int cnt);
    repeat (cnt)
    begin
      @(negedge ref_clk);
      raw_touched = t;
      sample_valid = 1'b1;
      @(negedge ref_clk);
      sample_valid = 1'b0;
    end
    @(negedge ref_clk);
  endtask : samp

  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 7; i++)
    begin
      host_inst.rd(adr[i], d);
      chk("reset value", rst[i], d);
    end
    for (int i = 0; i < 7; i++)
    begin
      host_inst.wr(adr[i], 8'ha5 ^ 8'(i));
      host_inst.rd(adr[i], d);
      chk("readback", (i == 6) ? 8'h00 : (i == 0) ? 8'h05 : 8'ha5 ^ 8'(i), d);
    end
    chk("accumulate out", 8'ha4, accumulate_count);
    for (int i = 0; i < 6; i++)
      host_inst.wr(adr[i], rst[i]);
  endtask : t_regs

  task automatic t_keys();
    samp(12'h006, 2);
    chk("early result", 12'h000, key_result);
    samp(12'h006, 1);
    chk("single key", 12'h002, key_result);
    host_inst.wr(8'h1f, 8'h19);
    repeat (2) @(negedge ref_clk);
    chk("noise mode", 12'h000, key_result);
    host_inst.wr(8'h1f, 8'h0d);
    repeat (2) @(negedge ref_clk);
    chk("multi key", 12'h006, key_result);
    samp(12'h000, 3);
    chk("released", 12'h000, key_result);
    host_inst.wr(8'h26, 8'h00);
    samp(12'h008, 1);
    chk("no debounce press", 12'h008, key_result);
    samp(12'h000, 1);
    chk("no debounce release", 12'h000, key_result);
    host_inst.wr(8'h26, 8'h02);
  endtask : t_keys

  task automatic t_holds();
    int n;
    samp(12'h001, 3);
    wait_for(3, 1100 * cyc_ms, n);
    chk("hold release", 1, n > 1000 * cyc_ms - 20 && n < 1000 * cyc_ms + 20);
    @(negedge ref_clk);
    chk("held key dropped", 12'h000, key_result);
    host_inst.wr(8'h1f, 8'h0f);
    raw_reverse = 12'h002;
    wait_for(4, 300 * cyc_ms, n);
    chk("reverse release", 1, n > 200 * cyc_ms - 20 && n < 200 * cyc_ms + 20);
    raw_reverse = 12'h000;
  endtask : t_holds

  task automatic tick_gap(input int ms);
    int n;
    wait_for(0, 1200 * cyc_ms, n);
    @(negedge ref_clk);
    wait_for(0, 1200 * cyc_ms, n);
    chk("track interval", 1, n + 1 > ms * cyc_ms - 12 && n + 1 < ms * cyc_ms + 12);
  endtask : tick_gap

  task automatic t_idle();
    int n;
    host_inst.wr(8'h23, 8'h00);
    idle_request = 1'b1;
    @(negedge ref_clk);
    idle_request = 1'b0;
    wait_for(1, 600 * cyc_ms, n);
    chk("idle entry", 1, n > 500 * cyc_ms - 20 && n < 500 * cyc_ms + 20);
    repeat (350 * cyc_ms) @(negedge ref_clk);
    chk("no wake below level", 1'b1, idle_active);
    touch_difference_value = 16'h0078;
    wait_for(2, 120 * cyc_ms, n);
    chk("wake in one check", 1, n < 100 * cyc_ms + 20);
    @(negedge ref_clk);
    chk("awake", 1'b0, idle_active);
  endtask : t_idle

  // checks every 200ms from idle entry: hit, miss, hit, hit
  task automatic t_wake_pairs();
    int n;
    idle_duty_period = 3'h1;
    touch_difference_value = 16'h0030;
    idle_request = 1'b1;
    @(negedge ref_clk);
    idle_request = 1'b0;
    wait_for(1, 600 * cyc_ms, n);
    chk("idle entry again", 1, n > 498 * cyc_ms && n < 502 * cyc_ms);
    touch_difference_value = 16'h0078;
    repeat (300 * cyc_ms) @(negedge ref_clk);
    touch_difference_value = 16'h0030;
    repeat (200 * cyc_ms) @(negedge ref_clk);
    chk("asleep after one hit", 1'b1, idle_active);
    touch_difference_value = 16'h0078;
    wait_for(2, 500 * cyc_ms, n);
    chk("wake on two hits", 1, n > 299 * cyc_ms && n < 301 * cyc_ms);
  endtask : t_wake_pairs

  initial
  begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    t_regs();
    t_keys();
    t_holds();
    tick_gap(200);
    host_inst.wr(8'h1f, 8'h05);
    tick_gap(1000);
    t_idle();
    t_wake_pairs();
    close_out();
  end

  initial
  begin
    #1000000;
    fail_count++;
    close_out();
  end
endmodule : touch_key_option_idle_wake_control_tb
